// ===== design/option_cfg_pkg.sv
package option_cfg_pkg;

  // option byte 0 field positions
  localparam int HALT_WDG_POS      = 7;  // reset on halt entry when set
  localparam int WDG_TYPE_POS      = 6;  // 0 hardware, 1 software
  localparam int CLK_SAFETY_POS    = 5;  // 0 clock filter and backup oscillator on
  localparam int VD_HI_POS         = 4;  // voltage detect level msb
  localparam int VD_LO_POS         = 3;  // voltage detect level lsb
  localparam int PKG_LO_POS        = 1;  // package select low bit
  localparam int READOUT_LOCK_POS  = 0;  // 0 protection on
  // option byte 1 field positions
  localparam int PKG_HI_POS        = 7;  // package select high bit
  localparam int RST_DELAY_POS     = 6;  // 0 long delay, 1 short delay
  localparam int OSC_KIND_HI_POS   = 5;  // oscillator kind msb
  localparam int OSC_KIND_LO_POS   = 4;  // oscillator kind lsb
  localparam int OSC_BAND_HI_POS   = 3;  // oscillator band msb
  localparam int OSC_BAND_LO_POS   = 1;  // oscillator band lsb
  localparam int DOUBLER_OFF_POS   = 0;  // 0 doubler on

  // erased flash content, and the as-shipped second byte with internal rc selected
  localparam logic [7:0] BYTE0_DEFAULT = 8'hE7;
  localparam logic [7:0] BYTE1_DEFAULT = 8'hEF;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;

  // reset phase lengths in cpu cycles
  localparam logic [12:0] LONG_DELAY_CYCLES  = 13'h1000;
  localparam logic [12:0] SHORT_DELAY_CYCLES = 13'h0100;

  // voltage detect codes
  localparam logic [1:0] VD_OFF     = 2'h3;
  localparam logic [1:0] VD_HIGHEST = 2'h0;

  // oscillator kinds
  typedef enum logic [1:0] {
    OSC_RESONATOR = 2'b00,
    OSC_EXT_RC    = 2'b01,
    OSC_INT_RC    = 2'b10,
    OSC_EXTERNAL  = 2'b11
  } osc_kind_type;

  // oscillator bands
  localparam logic [2:0] BAND_1_2MHZ  = 3'h0;
  localparam logic [2:0] BAND_2_4MHZ  = 3'h1;
  localparam logic [2:0] BAND_4_8MHZ  = 3'h2;
  localparam logic [2:0] BAND_8_16MHZ = 3'h3;

  // programming commands
  localparam logic [1:0] CMD_NONE  = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_ERASE = 2'h2;
  localparam logic [1:0] CMD_READ  = 2'h3;

  // loader sequence states
  typedef enum logic [1:0] {
    ST_LOAD     = 2'b00,
    ST_DELAY    = 2'b01,
    ST_RUN      = 2'b10,
    ST_HALT_EXT = 2'b11
  } load_state_type;

endpackage

// ===== design/reset_delay_counter.sv
`timescale 1ns/1ns
// counts a reset phase or halt-exit delay and flags completion
module reset_delay_counter (
  input  wire logic        clock,      // cpu clock
  input  wire logic        srst,       // synchronous reset, active high
  input  wire logic        start,      // one-cycle pulse: begin counting
  input  wire logic        short_sel,  // 1 selects the short delay
  output logic             busy,       // high while counting
  output logic             done        // one-cycle pulse at the end
);

  logic [12:0] count;       // cycles left
  logic [12:0] next_count;  // next cycles left
  logic        next_busy;   // next busy
  logic        next_done;   // next done

  // load on start, then count down to one
  always_comb begin
    next_count = count;
    next_busy  = busy;
    next_done  = 1'b0;
    if (start) begin
      next_count = short_sel ? option_cfg_pkg::SHORT_DELAY_CYCLES : option_cfg_pkg::LONG_DELAY_CYCLES;
      next_busy  = 1'b1;
    end else if (busy) begin
      if (count == 13'h0001) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 13'h0001;
      end
    end
  end

  // registers only
  always_ff @(posedge clock) begin
    if (srst) begin
      count <= 13'h0000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

endmodule

// ===== design/static_option_byte_decoder.sv
`timescale 1ns/1ns
// Function
// - halt with active watchdog resets if enabled
// - watchdog type hardware or software
// - clock safety bit low enables filter, backup
// - voltage detect field selects threshold or off
// - read-out lock low blocks test/programming access
// - option erase under lock erases user memory first
// - low supply detector off while locked
// - both package bits zero select 44-pin
// - unbonded pads reset as pulled-up inputs
// - delay select gives 4096 or 256 cycles
// - with clock safety, count starts at once
// - oscillator kind field picks clock source
// - band field sets resonator drive range
// - doubler off bit low enables doubling
// - option bytes reachable only in programming mode
// - mask variants use fixed factory values
// - flash delivered with internal rc selected
module static_option_byte_decoder #(
  parameter bit         MASK_VARIANT = 1'b0,   // 1: values come from factory code
  parameter logic [7:0] MASK_BYTE0   = 8'hE7,  // factory code byte 0
  parameter logic [7:0] MASK_BYTE1   = 8'hEF   // factory code byte 1
) (
  input  wire logic       clock,                       // cpu clock, 50 MHz
  input  wire logic       srst,                        // synchronous reset, active high
  input  wire logic       in_circuit_programming,      // programming mode active
  input  wire logic [1:0] prog_cmd,                    // programming command, one cycle
  input  wire logic       prog_sel,                    // 0 byte 0, 1 byte 1
  input  wire logic [7:0] prog_wdata,                  // write data
  input  wire logic       user_erase_done,             // user memory erase finished, pulse
  input  wire logic       watchdog_active,             // watchdog currently running
  input  wire logic       halt_request,                // cpu enters halt, pulse
  input  wire logic       halt_wakeup,                 // halt exit requested, pulse
  output logic [7:0]      prog_rdata,                  // read data
  output logic            prog_rvalid,                 // read data valid, pulse
  output logic            prog_busy,                   // erase sequence running
  output logic            user_erase_req,              // erase whole user memory, pulse
  output logic            halt_watchdog_reset_option,  // reset on halt entry enabled
  output logic            watchdog_type_select,        // 1 software watchdog
  output logic            watchdog_always_on,          // hardware watchdog forced on
  output logic            clock_safety_on,             // clock filter and backup osc on
  output logic [1:0]      voltage_detect_level,        // detector threshold code
  output logic            supply_drop_detector,        // low supply detector enable
  output logic            supply_warning_detector,     // supply warning detector enable
  output logic            readout_lock_n,              // 0 protection enabled
  output logic            readout_block,               // block flash access in test/icp
  output logic            package_44pin,               // 44-pin package selected
  output logic            unbonded_pad_pullup,         // unbonded pads held pulled-up inputs
  output logic            reset_delay_select,          // 1 short reset delay
  output logic [1:0]      oscillator_kind,             // main clock source
  output logic [2:0]      oscillator_band,             // resonator band or frequency
  output logic            band_1_2mhz,                 // resonator band 1-2 MHz
  output logic            band_2_4mhz,                 // resonator band 2-4 MHz
  output logic            band_4_8mhz,                 // resonator band 4-8 MHz
  output logic            band_8_16mhz,                // resonator band 8-16 MHz
  output logic            doubler_on,                  // clock doubler enabled
  output logic            delay_on_backup_clock,       // delay counted on backup osc
  output logic            cpu_reset,                   // cpu held in reset or halt exit
  output logic            halt_reset                   // reset from halt entry, pulse
);

  // non-volatile storage of the two option bytes
  // power-on content has internal rc selected
  logic [7:0] nv_byte0 = option_cfg_pkg::BYTE0_DEFAULT;  // stored byte 0, only clocked writes change it
  logic [7:0] nv_byte1 = option_cfg_pkg::BYTE1_DEFAULT;  // stored byte 1, only clocked writes change it
  logic [7:0] next_nv_byte0;   // next stored byte 0
  logic [7:0] next_nv_byte1;   // next stored byte 1
  // latched copies applied to the device
  logic [7:0] static_config_byte_0;       // applied byte 0
  logic [7:0] static_config_byte_1;       // applied byte 1
  logic [7:0] next_static_config_byte_0;  // next applied byte 0
  logic [7:0] next_static_config_byte_1;  // next applied byte 1
  logic       erase_pending;              // option erase waits for user erase
  logic       next_erase_pending;         // next erase pending
  logic       next_user_erase_req;        // next user erase pulse
  logic [7:0] next_prog_rdata;            // next read data
  logic       next_prog_rvalid;           // next read valid
  option_cfg_pkg::load_state_type state;       // loader state
  option_cfg_pkg::load_state_type next_state;  // next loader state
  logic       delay_start;                // start the delay counter
  logic       delay_busy;                 // counter running
  logic       delay_done;                 // counter finished
  logic       next_cpu_reset;             // next cpu reset
  logic       next_halt_reset;            // next halt reset
  logic       halt_to_reset;              // halt entry must reset

  // pick a bit of a byte
  function automatic logic pick(input logic [7:0] b, input int pos);
    pick = b[pos[2:0]];
  endfunction

  // storage and programming port
  always_comb begin
    next_nv_byte0       = nv_byte0;
    next_nv_byte1       = nv_byte1;
    next_erase_pending  = erase_pending;
    next_user_erase_req = 1'b0;
    next_prog_rdata     = prog_rdata;
    next_prog_rvalid    = 1'b0;
    if (in_circuit_programming && !erase_pending) begin
      unique case (prog_cmd)
        option_cfg_pkg::CMD_WRITE: begin
          // flash programming only clears bits
          if (prog_sel) begin
            next_nv_byte1 = nv_byte1 & prog_wdata;
          end else begin
            next_nv_byte0 = nv_byte0 & prog_wdata;
          end
        end
        option_cfg_pkg::CMD_ERASE: begin
          // locked part erases user memory first
          if (!pick(nv_byte0, option_cfg_pkg::READOUT_LOCK_POS)) begin
            next_erase_pending  = 1'b1;
            next_user_erase_req = 1'b1;
          end else begin
            next_nv_byte0 = option_cfg_pkg::ERASED_BYTE;
            next_nv_byte1 = option_cfg_pkg::ERASED_BYTE;
          end
        end
        option_cfg_pkg::CMD_READ: begin
          next_prog_rdata  = prog_sel ? nv_byte1 : nv_byte0;
          next_prog_rvalid = 1'b1;
        end
        option_cfg_pkg::CMD_NONE: begin
          next_prog_rvalid = 1'b0;
        end
      endcase
    end
    if (erase_pending && user_erase_done) begin
      next_nv_byte0      = option_cfg_pkg::ERASED_BYTE;
      next_nv_byte1      = option_cfg_pkg::ERASED_BYTE;
      next_erase_pending = 1'b0;
    end
  end

  // storage registers; the stored bytes are non-volatile and survive reset
  always_ff @(posedge clock) begin
    if (srst) begin
      erase_pending  <= 1'b0;
      user_erase_req <= 1'b0;
      prog_rdata     <= 8'h00;
      prog_rvalid    <= 1'b0;
      prog_busy      <= 1'b0;
    end else begin
      erase_pending  <= next_erase_pending;
      user_erase_req <= next_user_erase_req;
      prog_rdata     <= next_prog_rdata;
      prog_rvalid    <= next_prog_rvalid;
      prog_busy      <= next_erase_pending;
    end
    nv_byte0 <= next_nv_byte0;
    nv_byte1 <= next_nv_byte1;
  end

  // loader: capture during reset, then hold until next reset
  always_comb begin
    next_static_config_byte_0 = static_config_byte_0;
    next_static_config_byte_1 = static_config_byte_1;
    next_state                = state;
    delay_start               = 1'b0;
    next_halt_reset           = 1'b0;
    unique case (state)
      option_cfg_pkg::ST_LOAD: begin
        next_static_config_byte_0 = MASK_VARIANT ? MASK_BYTE0 : nv_byte0;
        next_static_config_byte_1 = MASK_VARIANT ? MASK_BYTE1 : nv_byte1;
        delay_start = 1'b1;
        next_state  = option_cfg_pkg::ST_DELAY;
      end
      option_cfg_pkg::ST_DELAY: begin
        if (delay_done) begin
          next_state = option_cfg_pkg::ST_RUN;
        end
      end
      option_cfg_pkg::ST_RUN: begin
        if (halt_request && halt_to_reset) begin
          next_halt_reset = 1'b1;
        end else if (halt_request) begin
          next_state = option_cfg_pkg::ST_HALT_EXT;
        end
      end
      option_cfg_pkg::ST_HALT_EXT: begin
        // halt exit uses the same delay
        if (halt_wakeup) begin
          delay_start = 1'b1;
          next_state  = option_cfg_pkg::ST_DELAY;
        end
      end
    endcase
  end

  assign halt_to_reset = pick(static_config_byte_0, option_cfg_pkg::HALT_WDG_POS) && watchdog_active;
  assign next_cpu_reset = (next_state != option_cfg_pkg::ST_RUN);

  // loader registers
  always_ff @(posedge clock) begin
    if (srst) begin
      state                <= option_cfg_pkg::ST_LOAD;
      static_config_byte_0 <= option_cfg_pkg::ERASED_BYTE;
      static_config_byte_1 <= option_cfg_pkg::ERASED_BYTE;
      cpu_reset            <= 1'b1;
      halt_reset           <= 1'b0;
    end else begin
      state                <= next_state;
      static_config_byte_0 <= next_static_config_byte_0;
      static_config_byte_1 <= next_static_config_byte_1;
      cpu_reset            <= next_cpu_reset;
      halt_reset           <= next_halt_reset;
    end
  end

  // delay length picked from the byte being applied
  reset_delay_counter u_delay (
    .clock     (clock),
    .srst      (srst),
    .start     (delay_start),
    .short_sel (pick(next_static_config_byte_1, option_cfg_pkg::RST_DELAY_POS)),
    .busy      (delay_busy),
    .done      (delay_done)
  );

  // decoded settings, registered so every output is a flip-flop
  always_ff @(posedge clock) begin
    if (srst) begin
      halt_watchdog_reset_option <= 1'b1;
      watchdog_type_select       <= 1'b1;
      watchdog_always_on         <= 1'b0;
      clock_safety_on            <= 1'b0;
      voltage_detect_level       <= option_cfg_pkg::VD_OFF;
      supply_drop_detector       <= 1'b0;
      supply_warning_detector    <= 1'b0;
      readout_lock_n             <= 1'b1;
      readout_block              <= 1'b0;
      package_44pin              <= 1'b0;
      unbonded_pad_pullup        <= 1'b1;
      reset_delay_select         <= 1'b1;
      oscillator_kind            <= option_cfg_pkg::OSC_INT_RC;
      oscillator_band            <= option_cfg_pkg::BAND_8_16MHZ;
      band_1_2mhz                <= 1'b0;
      band_2_4mhz                <= 1'b0;
      band_4_8mhz                <= 1'b0;
      band_8_16mhz               <= 1'b0;
      doubler_on                 <= 1'b0;
      delay_on_backup_clock      <= 1'b0;
    end else begin
      halt_watchdog_reset_option <= pick(static_config_byte_0, option_cfg_pkg::HALT_WDG_POS);
      watchdog_type_select       <= pick(static_config_byte_0, option_cfg_pkg::WDG_TYPE_POS);
      watchdog_always_on         <= !pick(static_config_byte_0, option_cfg_pkg::WDG_TYPE_POS);
      clock_safety_on            <= !pick(static_config_byte_0, option_cfg_pkg::CLK_SAFETY_POS);
      voltage_detect_level       <= static_config_byte_0[option_cfg_pkg::VD_HI_POS:option_cfg_pkg::VD_LO_POS];
      // code 11 turns both detectors off
      supply_drop_detector       <= (static_config_byte_0[option_cfg_pkg::VD_HI_POS:option_cfg_pkg::VD_LO_POS]
                                     != option_cfg_pkg::VD_OFF)
                                    && pick(static_config_byte_0, option_cfg_pkg::READOUT_LOCK_POS);
      supply_warning_detector    <= static_config_byte_0[option_cfg_pkg::VD_HI_POS:option_cfg_pkg::VD_LO_POS]
                                    != option_cfg_pkg::VD_OFF;
      // lock low blocks test and icp access
      readout_lock_n             <= pick(static_config_byte_0, option_cfg_pkg::READOUT_LOCK_POS);
      readout_block              <= !pick(static_config_byte_0, option_cfg_pkg::READOUT_LOCK_POS);
      package_44pin              <= !pick(static_config_byte_1, option_cfg_pkg::PKG_HI_POS)
                                    && !pick(static_config_byte_0, option_cfg_pkg::PKG_LO_POS);
      // pads stay pulled-up inputs after reset
      unbonded_pad_pullup        <= 1'b1;
      reset_delay_select         <= pick(static_config_byte_1, option_cfg_pkg::RST_DELAY_POS);
      oscillator_kind            <=
        static_config_byte_1[option_cfg_pkg::OSC_KIND_HI_POS:option_cfg_pkg::OSC_KIND_LO_POS];
      oscillator_band            <=
        static_config_byte_1[option_cfg_pkg::OSC_BAND_HI_POS:option_cfg_pkg::OSC_BAND_LO_POS];
      // drive range only for resonator source
      band_1_2mhz  <= is_res_band(option_cfg_pkg::BAND_1_2MHZ);
      band_2_4mhz  <= is_res_band(option_cfg_pkg::BAND_2_4MHZ);
      band_4_8mhz  <= is_res_band(option_cfg_pkg::BAND_4_8MHZ);
      band_8_16mhz <= is_res_band(option_cfg_pkg::BAND_8_16MHZ);
      // active-low doubler enable; bad combos are the programmer's problem
      doubler_on                 <= !pick(static_config_byte_1, option_cfg_pkg::DOUBLER_OFF_POS);
      delay_on_backup_clock      <= delay_busy && !pick(static_config_byte_0, option_cfg_pkg::CLK_SAFETY_POS);
    end
  end

  // resonator band match on the applied byte
  function automatic logic is_res_band(input logic [2:0] band);
    is_res_band = (static_config_byte_1[option_cfg_pkg::OSC_KIND_HI_POS:option_cfg_pkg::OSC_KIND_LO_POS]
                   == option_cfg_pkg::OSC_RESONATOR)
                  && (static_config_byte_1[option_cfg_pkg::OSC_BAND_HI_POS:option_cfg_pkg::OSC_BAND_LO_POS] == band);
  endfunction

endmodule

// ===== verification/static_option_byte_decoder_chk.sv
`timescale 1ns/1ns
// watches the decoder ports for timing and decode relations
module static_option_byte_decoder_chk (
  input wire logic       clock,                       // cpu clock
  input wire logic       srst,                        // sync reset
  input wire logic       in_circuit_programming,      // programming mode
  input wire logic [1:0] prog_cmd,                    // command
  input wire logic       prog_busy,                   // erase pending
  input wire logic       prog_rvalid,                 // read strobe
  input wire logic       user_erase_req,              // user erase pulse
  input wire logic       halt_request,                // halt entry
  input wire logic       watchdog_active,             // watchdog running
  input wire logic       halt_watchdog_reset_option,  // halt reset option
  input wire logic       cpu_reset,                   // cpu reset level
  input wire logic       halt_reset,                  // halt reset pulse
  input wire logic [1:0] voltage_detect_level,        // detector code
  input wire logic       supply_warning_detector,     // warning detector
  input wire logic       supply_drop_detector,        // drop detector
  input wire logic       readout_lock_n,              // lock, low active
  input wire logic       readout_block                // access blocked
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_rd; in_circuit_programming && !prog_busy && prog_cmd == 2'h3 |=> prog_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_mode; !in_circuit_programming |=> !prog_rvalid && !user_erase_req; endproperty
  a_mode: assert property (p_mode) else $error("command taken outside programming mode");
  property p_ebusy; user_erase_req |-> prog_busy; endproperty
  a_ebusy: assert property (p_ebusy) else $error("user erase without busy");
  property p_hrst;
    halt_request && watchdog_active && halt_watchdog_reset_option && !cpu_reset |=> halt_reset;
  endproperty
  a_hrst: assert property (p_hrst) else $error("no reset on halt entry");
  property p_hnone; halt_request && !halt_watchdog_reset_option |=> !halt_reset; endproperty
  a_hnone: assert property (p_hnone) else $error("reset on halt with option clear");
  property p_vd; supply_warning_detector == (voltage_detect_level != 2'h3); endproperty
  a_vd: assert property (p_vd) else $error("detector enable wrong");
  property p_lock; !readout_lock_n |-> readout_block && !supply_drop_detector; endproperty
  a_lock: assert property (p_lock) else $error("lock decode wrong");
  property p_hold; !srst [*4] |-> $stable({voltage_detect_level, readout_lock_n}); endproperty
  a_hold: assert property (p_hold) else $error("setting changed without reset");
endmodule

bind static_option_byte_decoder static_option_byte_decoder_chk chk (.*);

// ===== verification/prog_tool.sv
`timescale 1ns/1ns
// programming tool model driving the option byte port
module prog_tool (
  input  wire logic       clock,                   // cpu clock
  input  wire logic [7:0] prog_rdata,              // read data
  input  wire logic       prog_rvalid,             // read strobe
  output logic            in_circuit_programming,  // programming mode
  output logic [1:0]      prog_cmd,                // command
  output logic            prog_sel,                // byte select
  output logic [7:0]      prog_wdata               // write data
);
  // idle, out of programming mode
  initial begin
    in_circuit_programming = 1'b0;
    prog_cmd = 2'h0;
    prog_sel = 1'b0;
    prog_wdata = 8'h00;
  end
  task automatic issue(input logic mode, input logic [1:0] cmd, input logic s, input logic [7:0] d);
    @(negedge clock);
    in_circuit_programming = mode;
    prog_cmd = cmd;
    prog_sel = s;
    prog_wdata = d;
    @(negedge clock);
    prog_cmd = 2'h0;
    // released data must not keep its value
    prog_wdata = ~d;
  endtask
  // answer stands one cycle after the command
  task automatic read(input logic mode, input logic s, output logic ok, output logic [7:0] d);
    issue(mode, 2'h3, s, 8'h00);
    ok = prog_rvalid;
    d = prog_rdata;
  endtask
endmodule

// ===== verification/tb_static_option_byte_decoder.sv
`timescale 1ns/1ns
// programs option bytes through the tool and checks decoded settings
module tb_static_option_byte_decoder;
  localparam int LONG = 4096;  // long reset phase
  localparam int SHORT = 256;  // short reset phase
  logic clock, srst, user_erase_done, watchdog_active, halt_request, halt_wakeup, ok, bk;
  logic in_circuit_programming, prog_sel, prog_rvalid, prog_busy, user_erase_req;
  logic [1:0] prog_cmd, voltage_detect_level, oscillator_kind;
  logic [7:0] prog_wdata, prog_rdata, rd;
  logic [2:0] oscillator_band;
  logic halt_watchdog_reset_option, watchdog_type_select, watchdog_always_on, clock_safety_on;
  logic supply_drop_detector, supply_warning_detector, readout_lock_n, readout_block, package_44pin;
  logic unbonded_pad_pullup, reset_delay_select, band_1_2mhz, band_2_4mhz, band_4_8mhz, band_8_16mhz;
  logic doubler_on, delay_on_backup_clock, cpu_reset, halt_reset;
  int miscompares, n_compared, cnt;

  static_option_byte_decoder dut (.*);
  prog_tool tool (.*);

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // counts cycles until the cpu leaves reset; bounded so a hang ends the run
  task automatic wait_run();
    cnt = 0;
    while (cpu_reset !== 1'b0 && cnt < 5000) begin
      @(negedge clock);
      cnt++;
      if (cnt == 100)
        bk = delay_on_backup_clock;
    end
    if (cnt >= 5000) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic reboot(input int n);
    srst = 1'b1;
    repeat (n) @(negedge clock);
    srst = 1'b0;
    wait_run();
  endtask

  initial begin
    srst = 1'b1;
    user_erase_done = 1'b0;
    watchdog_active = 1'b0;
    halt_request = 1'b0;
    halt_wakeup = 1'b0;
    reboot(5);
    check(cnt >= SHORT && cnt <= SHORT + 4, 1, "short delay");
    check({halt_watchdog_reset_option, watchdog_type_select, watchdog_always_on, clock_safety_on,
           voltage_detect_level, readout_lock_n, package_44pin, bk}, 9'h184, "shipped byte 0");
    check({reset_delay_select, oscillator_kind, oscillator_band, doubler_on}, 7'h6E, "shipped byte 1");
    tool.read(1'b0, 1'b0, ok, rd);
    check(ok, 0, "read outside programming");
    tool.read(1'b1, 1'b1, ok, rd);
    check({ok, rd}, 9'h1EF, "byte 1 read");
    // resonator, 2-4 MHz, long delay, doubler on
    tool.issue(1'b1, 2'h1, 1'b0, 8'h81);
    tool.issue(1'b1, 2'h1, 1'b1, 8'h02);
    tool.read(1'b1, 1'b0, ok, rd);
    check({ok, rd, oscillator_kind}, 11'h606, "written, not applied");
    reboot(1);
    check(cnt >= LONG && cnt <= LONG + 4, 1, "long delay");
    check({halt_watchdog_reset_option, watchdog_type_select, watchdog_always_on, clock_safety_on,
           voltage_detect_level, readout_lock_n, package_44pin, bk}, 9'h167, "byte 0 decode");
    check({reset_delay_select, oscillator_kind, oscillator_band, doubler_on, band_1_2mhz, band_2_4mhz,
           band_4_8mhz, band_8_16mhz, unbonded_pad_pullup}, 12'h069, "byte 1 decode");
    // halt with the watchdog running resets
    watchdog_active = 1'b1;
    @(negedge clock) halt_request = 1'b1;
    @(negedge clock) halt_request = 1'b0;
    check(halt_reset, 1, "halt reset");
    // halt without the watchdog stops, then wakes after the long delay
    watchdog_active = 1'b0;
    @(negedge clock) halt_request = 1'b1;
    @(negedge clock) halt_request = 1'b0;
    check({cpu_reset, halt_reset}, 2'h2, "halt entry");
    @(negedge clock) halt_wakeup = 1'b1;
    @(negedge clock) halt_wakeup = 1'b0;
    wait_run();
    check(cnt >= LONG - 4 && cnt <= LONG + 4, 1, "halt exit delay");
    // every detector and oscillator kind code
    for (int i = 0; i < 4; i++) begin
      tool.issue(1'b1, 2'h2, 1'b0, 8'h00);
      tool.issue(1'b1, 2'h1, 1'b0, {3'h7, i[1:0], 3'h7});
      tool.issue(1'b1, 2'h1, 1'b1, {2'h3, i[1:0], 4'hF});
      reboot(1);
      check({voltage_detect_level, supply_warning_detector, supply_drop_detector, oscillator_kind},
            {i[1:0], i != 3, i != 3, i[1:0]}, "codes");
    end
    tool.issue(1'b1, 2'h1, 1'b0, 8'hE6);
    reboot(1);
    check({readout_lock_n, readout_block, supply_drop_detector, supply_warning_detector}, 4'h5, "lock");
    tool.issue(1'b1, 2'h2, 1'b0, 8'h00);
    check({user_erase_req, prog_busy}, 2'h3, "locked erase");
    tool.read(1'b1, 1'b0, ok, rd);
    check(ok, 0, "read while erasing");
    @(negedge clock) user_erase_done = 1'b1;
    @(negedge clock) user_erase_done = 1'b0;
    tool.read(1'b1, 1'b0, ok, rd);
    check({ok, rd, prog_busy}, 10'h3FE, "erased after user memory");
    // halt with the watchdog running but the option clear only stops the cpu
    tool.issue(1'b1, 2'h1, 1'b0, 8'h7F);
    reboot(1);
    watchdog_active = 1'b1;
    @(negedge clock) halt_request = 1'b1;
    @(negedge clock) halt_request = 1'b0;
    check({halt_watchdog_reset_option, cpu_reset, halt_reset}, 3'h2, "halt with option clear");
    summarize();
  end
endmodule
